// *** core/twrc_ctrl.sv ***
// Overview of operation
// [RULE1] Time base ticks every 2^12..2^15 timing clocks, chosen by option.
// [RULE2] Time base tick sets tick_irq_flag and shared_irq_flag.
// [RULE3] Pending enabled tick with free stack calls vector 18H.
// [RULE4] Time base tick may clock timer/event counter 1.
// [RULE5] Real-time-clock tick divides timing clock by 2^(8+clock_div_sel).
// [RULE6] Real-time-clock tick sets clock_irq_flag and shared_irq_flag.
// [RULE7] Real-time-clock tick may clock timer/event counter 0.
// [RULE8] Sleep stops system oscillator; timing clock keeps running.
// [RULE9] While asleep, RAM, registers and port states are held.
// [RULE10] Sleep entry clears the watchdog and restarts it.
// [RULE11] Sleep sets sleep_flag, clears expiry_flag; clear instr clears sleep.
// [RULE12] Wake on pin reset, interrupt, port A fall or watchdog.
// [RULE13] Watchdog in sleep: warm reset, sets expiry, clears PC and SP.
// [RULE14] Port A bits enabled per option; port wake resumes next instr.
// [RULE15] Interrupt wake resumes next if disabled or stack full.
// [RULE16] A flag set before sleep cannot wake the device.
// [RULE17] Each wake waits 1024 system clocks, then resumes at once.
// [RULE18] Start-up delay of 1024 clocks at power-up and wake.
// [RULE19] Flags tell power-up, pin, pin wake, watchdog, watchdog wake.
// [RULE20] Full reset: PC 000H, irqs off, dividers clear, ports input.
// [RULE21] Full reset clears dividers; watchdog counts after release.
// [RULE22] Software clears tick and clock flags; servicing never does.
// [RULE23] Wake delay counts from oscillator restart; fetch held meanwhile.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module twrc_ctrl
  import twrc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_q,
  output logic             pready_q,
  output logic             pslverr_q,
  input  wire logic        timing_clk_pin,
  input  wire logic        ext_clear_n_pin,
  input  wire logic [7:0]  port_a_pin,
  input  wire logic        sleep_instr,
  input  wire logic        dog_clear_instr,
  input  wire logic        stack_full,
  output logic             sys_osc_en_q,
  output logic             fetch_en_q,
  output logic             core_rst_q,
  output logic             warm_rst_q,
  output logic             pc_load_q,
  output logic      [11:0] pc_value_q,
  output logic             vec_call_q,
  output logic             resume_next_q,
  output logic             io_hold_q,
  output logic             tmr0_tick_q,
  output logic             tmr1_tick_q
);

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic low_ones(input logic [DIV_W-1:0] v,
                                    input logic [3:0] n);
    logic [15:0] m;
    m = (16'h0001 << n) - 16'h0001;
    low_ones = ((v & m[DIV_W-1:0]) == m[DIV_W-1:0]);
  endfunction

  twrc_state_e     st_q;
  twrc_kind_e      kind_q;
  logic [10:0]     dly_q;
  logic [1:0]      tclk_s_q, clr_s_q;
  logic [7:0]      pa_s1_q, pa_s2_q, pa_prev_q;
  logic            tclk_prev_q;
  logic [DIV_W-1:0] div_q, wdt_q;
  logic            tick_en_q, clk_en_q, tick_flg_q, clk_flg_q;
  logic            glob_en_q, shr_en_q, shr_flg_q;
  logic [2:0]      div_sel_q;
  logic            t0_src_q, t1_src_q;
  logic            sleep_flg_q, expiry_flg_q;
  logic [13:0]     opt_q;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tclk_s_q <= 2'b00;
      clr_s_q  <= 2'b11;
      pa_s1_q  <= 8'hFF;
      pa_s2_q  <= 8'hFF;
    end else begin
      tclk_s_q <= {tclk_s_q[0], timing_clk_pin};
      clr_s_q  <= {clr_s_q[0], ext_clear_n_pin};
      pa_s1_q  <= port_a_pin;
      pa_s2_q  <= pa_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tclk_prev_q <= 1'b0;
      pa_prev_q   <= 8'hFF;
    end else begin
      tclk_prev_q <= tclk_s_q[1];
      pa_prev_q   <= pa_s2_q;
    end
  end

  logic       pin_low, tclk_rise, pa_fall;
  logic [3:0] tb_n, rtc_n, wdt_n;
  logic       tb_tick, rtc_tick, wdt_ovf;
  assign pin_low   = ~clr_s_q[1];
  assign tclk_rise = tclk_s_q[1] & ~tclk_prev_q;
  assign pa_fall   = |(pa_prev_q & ~pa_s2_q & opt_q[7:0]); // [RULE14]

  // ****************************************************
  // Dividers and watchdog
  // ****************************************************
  assign tb_n  = TB_BASE + {2'b00, opt_q[9:8]};        // [RULE1]
  assign rtc_n = RTC_BASE + {1'b0, div_sel_q};         // [RULE5]
  assign wdt_n = WDT_BASE + {2'b00, opt_q[11:10]};
  assign tb_tick  = tclk_rise & low_ones(div_q, tb_n);  // [RULE1]
  assign rtc_tick = tclk_rise & low_ones(div_q, rtc_n); // [RULE5]
  assign wdt_ovf  = tclk_rise & opt_q[B_WDT_EN] &
                    low_ones(wdt_q, wdt_n);

  logic full_rst, sleep_go, warm_go;
  assign full_rst = (st_q == ST_PIN) ||
                    (st_q == ST_RUN && wdt_ovf);
  assign sleep_go = (st_q == ST_RUN) && fetch_en_q && sleep_instr;
  assign warm_go  = (st_q == ST_SLEEP) && wdt_ovf;

  // Shared prescaler keeps running in sleep since the timing clock does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (full_rst) begin
      div_q <= '0;                                     // [RULE21]
    end else if (tclk_rise) begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_q <= '0;
    end else if (full_rst || sleep_go || dog_clear_instr || warm_go) begin
      wdt_q <= '0;                                     // [RULE10] [RULE21]
    end else if (tclk_rise && opt_q[B_WDT_EN]) begin
      wdt_q <= wdt_q + 1'b1;
    end
  end

  // ****************************************************
  // Interrupt flags
  // ****************************************************
  logic wr_en, irq_ok, irq_pend, new_req;
  assign wr_en = psel & penable & pwrite & pready_q;
  assign irq_pend = (tick_flg_q & tick_en_q) | (clk_flg_q & clk_en_q);
  assign irq_ok = glob_en_q & shr_en_q & irq_pend & ~stack_full;
  // Only a freshly raised flag counts as a wake request
  assign new_req = (tb_tick & ~tick_flg_q) |
                   (rtc_tick & ~clk_flg_q);            // [RULE16]

  logic run_call;
  assign run_call = (st_q == ST_RUN) && fetch_en_q && shr_flg_q &&
                    irq_ok && !sleep_instr;            // [RULE3]

  // Set wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_flg_q <= 1'b0;
      clk_flg_q  <= 1'b0;
      tick_en_q  <= 1'b0;
      clk_en_q   <= 1'b0;
    end else if (full_rst) begin
      tick_flg_q <= 1'b0;
      clk_flg_q  <= 1'b0;
      tick_en_q  <= 1'b0;
      clk_en_q   <= 1'b0;
    end else begin
      if (wr_en && paddr == ADDR_SHARED) begin
        tick_en_q  <= pwdata[B_TICK_EN];
        clk_en_q   <= pwdata[B_CLK_EN];
        tick_flg_q <= pwdata[B_TICK_FLG];              // [RULE22]
        clk_flg_q  <= pwdata[B_CLK_FLG];               // [RULE22]
      end
      if (tb_tick) begin
        tick_flg_q <= 1'b1;                            // [RULE2]
      end
      if (rtc_tick) begin
        clk_flg_q <= 1'b1;                             // [RULE6]
      end
    end
  end

  // Vector call acknowledges the shared flag and masks further calls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shr_flg_q <= 1'b0;
      glob_en_q <= 1'b0;
      shr_en_q  <= 1'b0;
    end else if (full_rst) begin
      shr_flg_q <= 1'b0;                               // [RULE20]
      glob_en_q <= 1'b0;
      shr_en_q  <= 1'b0;
    end else begin
      if (wr_en && paddr == ADDR_CTRL1) begin
        glob_en_q <= pwdata[B_GLOB_EN];
        shr_en_q  <= pwdata[B_SHR_EN];
        shr_flg_q <= pwdata[B_SHR_FLG];
      end
      if (run_call || (vec_call_q && !run_call)) begin
        shr_flg_q <= 1'b0;
        glob_en_q <= 1'b0;
      end
      if (tb_tick || rtc_tick) begin
        shr_flg_q <= 1'b1;                             // [RULE2] [RULE6]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_sel_q <= CLK_SEL_RST;
      t0_src_q  <= 1'b0;
      t1_src_q  <= 1'b0;
    end else if (full_rst) begin
      div_sel_q <= CLK_SEL_RST;
      t0_src_q  <= 1'b0;
      t1_src_q  <= 1'b0;
    end else if (wr_en && paddr == ADDR_CLOCK) begin
      div_sel_q <= pwdata[2:0];                        // [RULE5]
      t0_src_q  <= pwdata[B_T0_SRC];
      t1_src_q  <= pwdata[B_T1_SRC];
    end
  end

  // Options are configuration, kept across every reset but power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_q <= OPT_RST;
    end else if (wr_en && paddr == ADDR_OPTION) begin
      opt_q <= pwdata[13:0];
    end
  end

  // ****************************************************
  // Reset cause flags
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_flg_q  <= 1'b0;                            // [RULE19]
      expiry_flg_q <= 1'b0;
    end else if (st_q == ST_RUN && wdt_ovf) begin
      expiry_flg_q <= 1'b1;                            // [RULE19]
    end else if (warm_go) begin
      expiry_flg_q <= 1'b1;                            // [RULE13]
    end else if (sleep_go) begin
      sleep_flg_q  <= 1'b1;                            // [RULE11]
      expiry_flg_q <= 1'b0;
    end else if (dog_clear_instr) begin
      sleep_flg_q  <= 1'b0;                            // [RULE11]
    end
  end

  // ****************************************************
  // Sleep and wake sequencer
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_WAKE;                               // [RULE18]
      kind_q <= K_FULL;
      dly_q  <= '0;
    end else begin
      case (st_q)
        ST_RUN: begin
          dly_q <= '0;
          if (pin_low) begin
            st_q   <= ST_PIN;
            kind_q <= K_NEXT;
          end else if (sleep_go) begin
            st_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          dly_q <= '0;
          if (pin_low) begin                           // [RULE12]
            st_q   <= ST_PIN;
            kind_q <= K_FULL;
          end else if (warm_go) begin
            st_q   <= ST_WAKE;
            kind_q <= K_WARM;
          end else if (new_req) begin
            st_q   <= ST_WAKE;
            kind_q <= K_IRQ;
          end else if (pa_fall) begin
            st_q   <= ST_WAKE;
            kind_q <= K_NEXT;                          // [RULE14]
          end
        end
        ST_PIN: begin
          // Pin reset while running needs no start-up wait
          dly_q <= '0;
          if (!pin_low) begin
            st_q <= (kind_q == K_FULL) ? ST_WAKE : ST_RUN;
          end
        end
        ST_WAKE: begin
          if (pin_low) begin
            st_q   <= ST_PIN;
            kind_q <= K_FULL;
          end else if (dly_q == WAKE_CYC - 11'd1) begin
            st_q <= ST_RUN;                            // [RULE17]
          end else begin
            dly_q <= dly_q + 11'd1;                    // [RULE23]
          end
        end
        default: begin
          st_q <= ST_RUN;
        end
      endcase
    end
  end

  logic wake_done;
  assign wake_done = (st_q == ST_WAKE) && !pin_low &&
                     (dly_q == WAKE_CYC - 11'd1);      // [RULE18]

  // Oscillator is off only in sleep; counting starts on its first edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_osc_en_q <= 1'b1;
      io_hold_q    <= 1'b0;
      fetch_en_q   <= 1'b0;
    end else begin
      sys_osc_en_q <= !(sleep_go || (st_q == ST_SLEEP &&
                        !(pin_low || warm_go || new_req || pa_fall)));
      io_hold_q    <= sleep_go || (st_q == ST_SLEEP && !pin_low); // [RULE9]
      if (sleep_go || (st_q == ST_RUN && pin_low)) begin
        fetch_en_q <= 1'b0;                            // [RULE8]
      end else if (wake_done ||
                   (st_q == ST_PIN && !pin_low && kind_q == K_NEXT)) begin
        fetch_en_q <= 1'b1;                            // [RULE23]
      end
    end
  end

  // ****************************************************
  // Core control strobes
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_rst_q    <= 1'b1;                           // [RULE20]
      warm_rst_q    <= 1'b0;
      vec_call_q    <= 1'b0;
      resume_next_q <= 1'b0;
      pc_load_q     <= 1'b0;
      pc_value_q    <= PC_RESET;
    end else begin
      warm_rst_q    <= wake_done && kind_q == K_WARM;  // [RULE13]
      vec_call_q    <= run_call ||
                       (wake_done && kind_q == K_IRQ && irq_ok);
      resume_next_q <= wake_done && (kind_q == K_NEXT ||
                       (kind_q == K_IRQ && !irq_ok)); // [RULE15] [RULE17]
      pc_load_q     <= 1'b0;
      if (full_rst ||
          (st_q == ST_WAKE && kind_q == K_FULL && !wake_done)) begin
        core_rst_q <= 1'b1;                            // [RULE20]
        pc_load_q  <= 1'b1;
        pc_value_q <= PC_RESET;
      end else begin
        core_rst_q <= 1'b0;
        if (wake_done && kind_q == K_WARM) begin
          pc_load_q  <= 1'b1;                          // [RULE13]
          pc_value_q <= PC_RESET;
        end else if (run_call ||
                     (wake_done && kind_q == K_IRQ && irq_ok)) begin
          pc_load_q  <= 1'b1;                          // [RULE3] [RULE15]
          pc_value_q <= PC_VECT;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr0_tick_q <= 1'b0;
      tmr1_tick_q <= 1'b0;
    end else begin
      tmr0_tick_q <= rtc_tick & t0_src_q;              // [RULE7]
      tmr1_tick_q <= tb_tick & t1_src_q;               // [RULE4]
    end
  end

  // ****************************************************
  // APB slave, one wait-free access phase
  // ****************************************************
  logic [31:0] rd_mux;
  logic        hit;
  always_comb begin
    rd_mux = '0;
    hit    = 1'b1;
    case (paddr)
      ADDR_SHARED: begin
        rd_mux[B_TICK_EN]  = tick_en_q;
        rd_mux[B_CLK_EN]   = clk_en_q;
        rd_mux[B_TICK_FLG] = tick_flg_q;
        rd_mux[B_CLK_FLG]  = clk_flg_q;
      end
      ADDR_CTRL1: begin
        rd_mux[B_GLOB_EN] = glob_en_q;
        rd_mux[B_SHR_EN]  = shr_en_q;
        rd_mux[B_SHR_FLG] = shr_flg_q;
      end
      ADDR_CLOCK: begin
        rd_mux[2:0]      = div_sel_q;
        rd_mux[B_T0_SRC] = t0_src_q;
        rd_mux[B_T1_SRC] = t1_src_q;
      end
      ADDR_STATUS: begin
        rd_mux[B_ASLEEP] = (st_q == ST_SLEEP);
        rd_mux[B_WAKING] = (st_q == ST_WAKE);
        rd_mux[B_SLEEP]  = sleep_flg_q;                // [RULE19]
        rd_mux[B_EXPIRY] = expiry_flg_q;
      end
      ADDR_OPTION: begin
        rd_mux[13:0] = opt_q;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit;
      if (psel && !penable && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

endmodule // twrc_ctrl

// *** core/twrc_pkg.sv ***
package twrc_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] ADDR_SHARED = 8'h00;
  localparam logic [7:0] ADDR_CTRL1  = 8'h04;
  localparam logic [7:0] ADDR_CLOCK  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_OPTION = 8'h10;

  // shared_irq_ctrl_reg fields
  localparam int B_TICK_EN  = 1;
  localparam int B_CLK_EN   = 2;
  localparam int B_TICK_FLG = 5;
  localparam int B_CLK_FLG  = 6;
  // irq_ctrl1_reg fields
  localparam int B_GLOB_EN  = 0;
  localparam int B_SHR_EN   = 4;
  localparam int B_SHR_FLG  = 6;
  // clock_ctrl_reg fields
  localparam int B_T0_SRC   = 3;
  localparam int B_T1_SRC   = 4;
  localparam logic [2:0] CLK_SEL_RST = 3'h7;
  // status fields
  localparam int B_ASLEEP   = 0;
  localparam int B_WAKING   = 1;
  localparam int B_SLEEP    = 4;
  localparam int B_EXPIRY   = 5;
  // option register fields
  localparam int B_WDT_EN   = 12;
  localparam logic [13:0] OPT_RST = 14'h1000;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int         DIV_W     = 15;
  localparam logic [3:0] TB_BASE   = 4'hC;
  localparam logic [3:0] RTC_BASE  = 4'h8;
  localparam logic [3:0] WDT_BASE  = 4'hC;
  localparam logic [10:0] WAKE_CYC = 11'd1024;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] PC_VECT  = 12'h018;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b10,
    ST_PIN   = 2'b11
  } twrc_state_e;

  typedef enum logic [1:0] {
    K_FULL = 2'b00,
    K_NEXT = 2'b01,
    K_IRQ  = 2'b10,
    K_WARM = 2'b11
  } twrc_kind_e;

endpackage

// *** testbench/twrc_core_model.sv ***
`timescale 1ns/1ps
module twrc_core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fetch_en_q,
  input  wire logic sleep_req,
  input  wire logic clr_req,
  output logic      timing_clk_pin,
  output logic      sleep_instr,
  output logic      dog_clear_instr
);
  // ******
  // Timing clock and core pulses
  // ******
  logic [1:0] div_q;

  // Timing source runs free, also while the core sleeps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= '0;
    else div_q <= div_q + 2'h1;
  end
  assign timing_clk_pin = div_q[1];

  // A stopped core issues no instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_instr     <= 1'b0;
      dog_clear_instr <= 1'b0;
    end else begin
      sleep_instr     <= sleep_req & fetch_en_q;
      dog_clear_instr <= clr_req & fetch_en_q;
    end
  end
endmodule // twrc_core_model

// *** testbench/twrc_ctrl_properties.sv ***
`timescale 1ns/1ps
module twrc_chk
  import twrc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        sleep_instr,
  input wire logic        stack_full,
  input wire logic        sys_osc_en_q,
  input wire logic        fetch_en_q,
  input wire logic        core_rst_q,
  input wire logic        warm_rst_q,
  input wire logic        pc_load_q,
  input wire logic [11:0] pc_value_q,
  input wire logic        vec_call_q,
  input wire logic        resume_next_q,
  input wire logic        io_hold_q
);
  // ******
  // Cycles spent with oscillator on and fetch held
  // ******
  logic [10:0] wcnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wcnt_q <= '0;
    else if (!sys_osc_en_q || fetch_en_q) wcnt_q <= '0;
    else if (wcnt_q != 11'h7FF) wcnt_q <= wcnt_q + 11'h1;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sleep_entry: assert property (
    sleep_instr && fetch_en_q |=> !sys_osc_en_q && io_hold_q && !fetch_en_q)
    else $error("sleep entry not taken");
  a_osc_cause: assert property (
    $fell(sys_osc_en_q) |-> $past(sleep_instr))
    else $error("oscillator stopped without sleep");
  a_hold_io: assert property (
    !sys_osc_en_q |-> io_hold_q && !fetch_en_q)
    else $error("ports or fetch not held in sleep");
  a_vect_call: assert property (
    vec_call_q |-> pc_load_q && pc_value_q == PC_VECT && !resume_next_q)
    else $error("vector call target wrong");
  a_vect_stack: assert property (
    vec_call_q |-> !$past(stack_full))
    else $error("vector call with full stack");
  a_warm_pc: assert property (
    warm_rst_q |-> (pc_load_q && pc_value_q == PC_RESET) ##1 !warm_rst_q)
    else $error("warm reset wrong");
  // A call taken while running has no wake delay in front of it
  a_wake_min: assert property (
    resume_next_q || warm_rst_q || (vec_call_q && !$past(fetch_en_q)) |->
    wcnt_q >= 11'd1023)
    else $error("wake delay too short");
  a_delay_cap: assert property (
    wcnt_q <= 11'd1100)
    else $error("start-up delay too long");
  a_boot_state: assert property (
    $rose(presetn) |-> (core_rst_q && !fetch_en_q) [*8])
    else $error("reset state not held");
endmodule // twrc_chk

bind twrc_ctrl twrc_chk u_chk (.pclk, .presetn, .sleep_instr, .stack_full,
  .sys_osc_en_q, .fetch_en_q, .core_rst_q, .warm_rst_q, .pc_load_q,
  .pc_value_q, .vec_call_q, .resume_next_q, .io_hold_q);

// *** testbench/tick_sleep_wake_reset_ctrl_tb.sv ***
`timescale 1ns/1ps
module tick_sleep_wake_reset_ctrl_tb
  import twrc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q;
  logic [7:0]  paddr, port_a_pin;
  logic [31:0] pwdata, prdata_q, rd, seed;
  logic        timing_clk_pin, ext_clear_n_pin, sleep_instr, dog_clear_instr;
  logic        stack_full, sys_osc_en_q, fetch_en_q, core_rst_q, warm_rst_q;
  logic        pc_load_q, vec_call_q, resume_next_q, io_hold_q, er;
  logic        tmr0_tick_q, tmr1_tick_q, sleep_req, clr_req, m_slp, m_exp;
  logic [11:0] pc_value_q;
  logic [2:0]  ev;
  int          err_total, compares, c, i;

  twrc_ctrl dut (.*);
  twrc_core_model u_core (.*);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ******
  // Helpers
  // ******
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready_q !== 1'b1 && k < 40);
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 40) chk(0, 1, "bus hang");
  endtask

  // Waits bounded: a lost pulse must not stall the run
  task automatic wsig(input int s, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      ev = {warm_rst_q, vec_call_q, resume_next_q};
    end while (!(s == 0 ? tmr0_tick_q : s == 1 ? tmr1_tick_q :
                 s == 2 ? fetch_en_q : |ev) && n < 40000);
    if (n >= 40000) chk(0, 1, "no event");
  endtask

  task automatic nap();
    sleep_req <= 1'b1;
    @(posedge pclk) sleep_req <= 1'b0;
    repeat (3) @(posedge pclk);
    m_slp = 1'b1;
    m_exp = 1'b0;
    chk({sys_osc_en_q, io_hold_q}, 2'b01, "sleep");
  endtask

  task automatic st();
    apb(1'b0, ADDR_STATUS, 0);
    chk(rd & 32'h30, 32'({m_exp, m_slp}) << B_SLEEP, "flags");
  endtask

  task automatic pin(input int n);
    ext_clear_n_pin <= 1'b0;
    repeat (n) @(posedge pclk);
    chk(fetch_en_q, 0, "pin hold");
    ext_clear_n_pin <= 1'b1;
    wsig(2, c);
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge pclk);
    chk(0, 1, "timeout");
    finish_test();
  end

  // ******
  // Scenarios
  // ******
  initial begin
    {psel, penable, pwrite, sleep_req, clr_req, stack_full} = '0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    ext_clear_n_pin = 1'b1;
    port_a_pin = 8'hFF;
    seed = 32'h193C;
    {err_total, compares} = '0;
    {m_slp, m_exp} = 2'b00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wsig(2, c);
    chk(c >= 1024 && c <= 1030, 1, "startup");
    st();
    apb(1'b0, ADDR_CLOCK, 0);
    chk(rd, 32'(CLK_SEL_RST), "div reset");
    apb(1'b0, ADDR_OPTION, 0);
    chk(rd, 32'(OPT_RST), "option reset");
    apb(1'b0, ADDR_SHARED, 0);
    chk(rd, 0, "irq off");
    apb(1'b0, 8'h14, 0);
    chk({rd[30:0], er}, 1, "unmapped");
    $display("test reset finished");
    apb(1'b1, ADDR_OPTION, 32'h1);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, ADDR_CLOCK, 32'h18 | i);
      apb(1'b0, ADDR_CLOCK, 0);
      chk(rd, 32'h18 | i, "div code");
    end
    for (i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_CLOCK, 32'h18 | i);
      wsig(0, c);
      wsig(0, c);
      chk(c, 4 << (8 + i), "rtc period");
    end
    apb(1'b0, ADDR_SHARED, 0);
    chk(rd[B_CLK_FLG], 1, "rtc flag");
    apb(1'b0, ADDR_CTRL1, 0);
    chk(rd[B_SHR_FLG], 1, "shared flag");
    apb(1'b1, ADDR_SHARED, 0);
    apb(1'b1, ADDR_CTRL1, 0);
    wsig(1, c);
    wsig(1, c);
    chk(c, 4 << 12, "base period");
    apb(1'b0, ADDR_SHARED, 0);
    chk(rd[B_TICK_FLG], 1, "base flag");
    $display("test ticks finished");
    apb(1'b1, ADDR_OPTION, 32'h301);
    apb(1'b1, ADDR_CLOCK, 32'h8);
    for (i = 0; i < 2; i++) begin
      stack_full <= i[0];
      wsig(0, c);
      apb(1'b1, ADDR_SHARED, 32'h1 << B_CLK_EN);
      apb(1'b1, ADDR_CTRL1, 32'h11);
      nap();
      wsig(3, c);
      chk(c >= 1900 && c <= 2100, 1, "irq delay");
      chk(ev, i ? 3'b001 : 3'b010, "irq wake");
      chk(pc_load_q ? pc_value_q : 12'hFFF,
          i ? 12'hFFF : PC_VECT, "vector");
      st();
    end
    // Fast tick while the clock flag is still set: it must not wake
    apb(1'b1, ADDR_CLOCK, 32'h8);
    stack_full <= 1'b0;
    nap();
    repeat (300) begin
      repeat (5) @(posedge pclk);
      port_a_pin <= 8'(xs()) | 8'h01;
    end
    chk(sys_osc_en_q, 0, "stale flag");
    port_a_pin <= 8'hFE;
    wsig(3, c);
    chk(ev, 3'b001, "port wake");
    chk(c >= 1024 && c <= 1040, 1, "port delay");
    port_a_pin <= 8'hFF;
    apb(1'b1, ADDR_OPTION, 32'h1301);
    nap();
    wsig(3, c);
    chk(c >= 17400 && c <= 17480, 1, "dog delay");
    chk(ev, 3'b100, "dog wake");
    apb(1'b1, ADDR_OPTION, 32'h301);
    m_exp = 1'b1;
    st();
    clr_req <= 1'b1;
    @(posedge pclk) clr_req <= 1'b0;
    repeat (3) @(posedge pclk);
    m_slp = 1'b0;
    st();
    nap();
    pin(5);
    chk(c >= 1024 && c <= 1040, 1, "pin delay");
    st();
    apb(1'b0, ADDR_OPTION, 0);
    chk(rd, 32'h301, "option kept");
    pin(5);
    chk(c <= 10, 1, "run pin");
    st();
    $display("test sleep finished");
    finish_test();
  end
endmodule // tick_sleep_wake_reset_ctrl_tb
